/* hdl/interlock_brake_supervisor.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module interlock_brake_supervisor #(
    parameter int ms_div = ibs_pkg::ms_cycles
)(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [17:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 interlock_in,
    input  wire logic                 seq_delay_done,
    input  wire logic signed [15:0]   motor_rpm,
    input  wire logic signed [31:0]   motor_pos,
    input  wire logic [15:0]          zero_speed_threshold,
    input  wire logic [1:0]           parking_brake_kind,
    input  wire logic [15:0]          high_speed_rpm,
    output ibs_pkg::drive_t           drive,
    output logic                      tiedown_ok,
    output logic                      irq
);
    typedef struct packed {
        ibs_pkg::cfg_t      cfg;
        ibs_pkg::seq_t      seq;
        logic [3:0]         status;
        logic [1:0]         il_sync;
        logic [31:0]        div;
        logic               tick;
        logic [15:0]        t_tmo;   // timeout counter, ms
        logic [15:0]        t_set;   // settle counter, ms
        logic [15:0]        t_sup;   // ms since interlock off
        logic [15:0]        t_tie;   // tiedown counter
        logic               tie_busy;
        logic [7:0]         t_over;
        logic [31:0]        env;     // envelope, rpm << 16
        logic               crossed;
        logic signed [31:0] zpos;
        logic [31:0]        prdata;
        ibs_pkg::drive_t    drive;
    } st_t;

    // registered state and its next value
    st_t cur, nxt;

    // bus decode
    logic        wr, rd;
    logic [15:0] widx;

    // speed and travel helpers
    logic        il_on, moving;
    logic [15:0] spd_abs;
    logic [31:0] roll_abs, env_step, env_init;

    // access phase strobes
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;

    // word index from byte address
    assign widx    = paddr[17:2];

    // the slave never stalls or errors
    assign pready  = 1'b1;        // zero wait states
    assign pslverr = 1'b0;

    // outputs straight from flops
    assign prdata  = cur.prdata;
    assign drive   = cur.drive;

    // window over, no fault seen
    assign tiedown_ok = !cur.tie_busy && !cur.status[ibs_pkg::st_tiedown];

    // level irq from masked sticky bits
    assign irq     = |(cur.status & cur.cfg.mask);

    // next-state logic; one update per pclk, slow timers advance on tick
    always_comb
    begin
        // hold everything by default
        nxt      = cur;

        // only the second sync flop is read
        il_on    = cur.il_sync[1];

        // speed magnitude, either direction
        spd_abs  = motor_rpm[15] ? 16'(-motor_rpm) : motor_rpm;

        // at or below threshold counts as stopped
        moving   = spd_abs > zero_speed_threshold;

        // travel since first zero crossing
        roll_abs = 32'(motor_pos - cur.zpos);
        if (roll_abs[31])
            roll_abs = 32'(-roll_abs);

        // falling slope per ms: typical max over ramp rate
        env_step = (cur.cfg.ramp_rate == 16'h0) ? 32'hffffffff
                 : 32'(({16'h0, ibs_pkg::typ_max_rpm} << 16) / {16'h0, cur.cfg.ramp_rate});
        // scale of one plus tolerance taken as additive rpm margin
        env_init = 32'({16'h0, spd_abs} + {16'h0, cur.cfg.tolerance}) << 16;

        // two flops: interlock is a pin
        nxt.il_sync = {cur.il_sync[0], interlock_in};

        // millisecond tick, one cycle wide
        // a single clock: slow timers use it as enable
        nxt.tick    = 1'b0;
        nxt.div     = cur.div + 32'h1;
        if (cur.div >= 32'(ms_div - 1))
        begin
            nxt.div  = 32'h0;
            nxt.tick = 1'b1;
        end

        // register writes
        // taken at the access edge only
        // unmapped words are ignored
        if (wr)
        begin
            case (widx)
                ibs_pkg::idx_decel_hs:   nxt.cfg.decel_hs   = pwdata[15:0];
                ibs_pkg::idx_decel_ls:   nxt.cfg.decel_ls   = pwdata[15:0];
                ibs_pkg::idx_enable:     nxt.cfg.enable     = pwdata[0];
                ibs_pkg::idx_timeout:    nxt.cfg.timeout    = pwdata[15:0];
                ibs_pkg::idx_ramp_delay: nxt.cfg.ramp_delay = pwdata[15:0];
                ibs_pkg::idx_ramp_rate:  nxt.cfg.ramp_rate  = pwdata[15:0];
                ibs_pkg::idx_tolerance:  nxt.cfg.tolerance  = pwdata[15:0];
                ibs_pkg::idx_sup_en:     nxt.cfg.sup_en     = pwdata[0];
                ibs_pkg::idx_roll_limit: nxt.cfg.roll_limit = pwdata[15:0];
                ibs_pkg::idx_settle:     nxt.cfg.settle     = pwdata[15:0];
                ibs_pkg::idx_tiedown:    nxt.cfg.tiedown    = pwdata[15:0];
                ibs_pkg::idx_mask:       nxt.cfg.mask       = pwdata[3:0];
                default: ;
            endcase
        end

        // register reads; status read clears, events below win over it
        // data latched in read setup, held until the next read setup
        // so the master can take it at the access edge
        if (psel && !penable && !pwrite)
        begin
            case (widx)
                ibs_pkg::idx_decel_hs:   nxt.prdata = {16'h0, cur.cfg.decel_hs};
                ibs_pkg::idx_decel_ls:   nxt.prdata = {16'h0, cur.cfg.decel_ls};
                ibs_pkg::idx_enable:     nxt.prdata = {31'h0, cur.cfg.enable};
                ibs_pkg::idx_timeout:    nxt.prdata = {16'h0, cur.cfg.timeout};
                ibs_pkg::idx_ramp_delay: nxt.prdata = {16'h0, cur.cfg.ramp_delay};
                ibs_pkg::idx_ramp_rate:  nxt.prdata = {16'h0, cur.cfg.ramp_rate};
                ibs_pkg::idx_tolerance:  nxt.prdata = {16'h0, cur.cfg.tolerance};
                ibs_pkg::idx_sup_en:     nxt.prdata = {31'h0, cur.cfg.sup_en};
                ibs_pkg::idx_roll_limit: nxt.prdata = {16'h0, cur.cfg.roll_limit};
                ibs_pkg::idx_settle:     nxt.prdata = {16'h0, cur.cfg.settle};
                ibs_pkg::idx_tiedown:    nxt.prdata = {16'h0, cur.cfg.tiedown};
                ibs_pkg::idx_status:     nxt.prdata = {28'h0, cur.status};
                ibs_pkg::idx_mask:       nxt.prdata = {28'h0, cur.cfg.mask};
                ibs_pkg::idx_state:      nxt.prdata = {27'h0, cur.seq};
                default:                 nxt.prdata = 32'h0;
            endcase
        end

        // read of status clears it
        if (rd && widx == ibs_pkg::idx_status)
            nxt.status = 4'h0;

        // key-on tiedown: interlock must read off for the whole window
        // a shorted switch would read on
        // and then is flagged as a fault
        if (cur.tie_busy && cur.tick)
        begin
            if (il_on)
                nxt.status[ibs_pkg::st_tiedown] = 1'b1;
            if (cur.t_tie + 16'h1 >= cur.cfg.tiedown)
                nxt.tie_busy = 1'b0;
            nxt.t_tie = cur.t_tie + 16'h1;
        end

        // zero time switches the check off
        if (cur.cfg.tiedown == 16'h0)
            nxt.tie_busy = 1'b0;

        // braking sequencer
        // regen is only asked for while braking, or in settle while still moving
        nxt.drive.regen_stop = 1'b0;

        case (cur.seq)
            // interlock on: drive normally
            ibs_pkg::s_idle:
            begin
                // power stage up, brake released
                nxt.drive.bridge_en     = 1'b1;
                nxt.drive.contactor     = 1'b1;
                nxt.drive.parking_brake = 1'b0;

                // timers restart, so they count from removal
                nxt.t_tmo = 16'h0;
                nxt.t_sup = 16'h0;
                nxt.t_over = 8'h0;
                nxt.crossed = 1'b0;

                // envelope tracks entry speed
                nxt.env = env_init;

                // no braking while the key-on window runs
                if (!il_on && cur.tie_busy == 1'b0)
                    nxt.seq = cur.cfg.enable ? ibs_pkg::s_brake : ibs_pkg::s_coast;
            end

            // regen stop toward zero speed
            ibs_pkg::s_brake:
            begin
                nxt.drive.regen_stop = 1'b1;

                // rate picked by present speed
                nxt.drive.decel_rate = (spd_abs >= high_speed_rpm)
                                     ? cur.cfg.decel_hs
                                     : cur.cfg.decel_ls;

                // timeout count in milliseconds
                if (cur.tick)
                    nxt.t_tmo = cur.t_tmo + 16'h1;

                // timeout counted in 8 ms units of the raw field
                // escalation is one event: status set only once
                if ((parking_brake_kind == 2'd1 || parking_brake_kind == 2'd2)
                    && cur.tick && (cur.t_tmo >= 16'(cur.cfg.timeout * ibs_pkg::tmo_unit_ms))
                    && moving && !cur.drive.parking_brake)
                begin
                    nxt.drive.parking_brake = 1'b1;
                    nxt.status[ibs_pkg::st_timeout] = 1'b1;
                end

                // stopped: hold position a while
                if (!moving)
                begin
                    nxt.seq   = ibs_pkg::s_settle;
                    nxt.t_set = 16'h0;
                end
            end

            // position hold after zero speed
            ibs_pkg::s_settle:
            begin
                // position hold runs with contactor and bridge kept on
                nxt.drive.regen_stop = moving;
                if (cur.tick)
                    nxt.t_set = cur.t_set + 16'h1;

                // settle time over: stand down
                if (cur.t_set >= cur.cfg.settle)
                    nxt.seq = ibs_pkg::s_done;
            end

            // no regen: bridge off after delay
            ibs_pkg::s_coast:
            begin
                // the external sequencer owns the delay
                if (seq_delay_done)
                begin
                    nxt.drive.bridge_en = 1'b0;
                    nxt.seq = ibs_pkg::s_done;
                end
            end

            // sequence finished
            ibs_pkg::s_done:
            begin
                // bridge off in both cases
                nxt.drive.bridge_en     = 1'b0;
                nxt.drive.contactor     = !cur.cfg.enable;

                // coasting keeps wheels free, a regen stop parks
                nxt.drive.parking_brake = cur.cfg.enable;
            end

            // illegal code: back to idle
            default: nxt.seq = ibs_pkg::s_idle;
        endcase

        // interlock back on ends any sequence
        if (il_on && cur.seq != ibs_pkg::s_idle)
            nxt.seq = ibs_pkg::s_idle;

        // supervision envelope and rollback while braking or settling
        if (cur.seq == ibs_pkg::s_brake || cur.seq == ibs_pkg::s_settle)
        begin
            // ms since removal, saturating
            if (cur.tick && cur.t_sup < 16'hffff)
                nxt.t_sup = cur.t_sup + 16'h1;

            // flat first, then falling
            if (cur.tick && cur.t_sup >= cur.cfg.ramp_delay)
                nxt.env = (cur.env > env_step) ? cur.env - env_step : 32'h0;

            // count ms spent above the envelope
            // any dip below restarts the count
            if (cur.tick)
            begin
                if ({16'h0, spd_abs} > (cur.env >> 16)
                    + {16'h0, zero_speed_threshold})
                    nxt.t_over = (cur.t_over < 8'hff) ? cur.t_over + 8'h1 : cur.t_over;
                else
                    nxt.t_over = 8'h0;
            end

            // persistent overspeed faults
            if (cur.cfg.sup_en && cur.t_over >= ibs_pkg::persist_ms)
                nxt.status[ibs_pkg::st_overspd] = 1'b1;

            // remember position at first zero crossing
            if (!moving && !cur.crossed)
            begin
                nxt.crossed = 1'b1;
                nxt.zpos    = motor_pos;
            end

            // limit raw units match position counts, 4096 per rev
            if (cur.cfg.sup_en && cur.crossed
                && roll_abs > {16'h0, cur.cfg.roll_limit})
                nxt.status[ibs_pkg::st_rollbk] = 1'b1;
        end
    end

    // state register; reset loads documented defaults
    // only constants in the reset branch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // clear all, then load defaults
            cur <= '0;

            // sync starts at the idle level of the pin
            // so no false removal follows reset
            cur.il_sync        <= 2'b11;

            // settings at their defaults
            cur.cfg.decel_hs   <= ibs_pkg::rst_decel_hs;
            cur.cfg.decel_ls   <= ibs_pkg::rst_decel_ls;
            cur.cfg.timeout    <= ibs_pkg::rst_timeout;
            cur.cfg.ramp_delay <= ibs_pkg::rst_ramp_delay;
            cur.cfg.ramp_rate  <= ibs_pkg::rst_ramp_rate;
            cur.cfg.tolerance  <= ibs_pkg::rst_tolerance;
            cur.cfg.roll_limit <= ibs_pkg::rst_roll_limit;
            cur.cfg.settle     <= ibs_pkg::rst_settle;
            cur.cfg.tiedown    <= ibs_pkg::rst_tiedown;

            // both switches default on
            cur.cfg.enable     <= 1'b1;
            cur.cfg.sup_en     <= 1'b1;

            // sequencer idles
            cur.seq            <= ibs_pkg::s_idle;
            cur.tie_busy       <= 1'b1;  // key-on window starts at reset release
        end
        else
            // one update per clock
            cur <= nxt;
    end
endmodule

/* hdl/ibs_pkg.sv */
// What this block does
// - enabled: interlock off commands regen stop
// - disabled: bridge off after sequencing delay
// - high-speed decel rate programmable, default 1.5s
// - low-speed decel rate programmable, default 2.0s
// - hold contactor and bridge for settle time
// - timeout timer starts at interlock removal
// - timeout before zero speed engages parking brake
// - regen continues with parking brake while moving
// - timeout only for brake kind 1 or 2
// - supervision switch gates all supervision faults
// - key-on: interlock must stay off tiedown time; never checked: tiedown resets to 0, which ends the window on the first clock
// - tiedown time zero disables the check
// - envelope is initial speed plus tolerance
// - envelope flat for ramp delay
// - envelope then falls at ramp rate
// - rollback beyond limit after zero crossing faults
package ibs_pkg;
    // register word indices (printed offset is word index)
    localparam logic [15:0] idx_decel_hs   = 16'h30f4;
    localparam logic [15:0] idx_decel_ls   = 16'h30f5;
    localparam logic [15:0] idx_enable     = 16'h30f6;
    localparam logic [15:0] idx_timeout    = 16'h30f7;
    localparam logic [15:0] idx_ramp_delay = 16'h3118;
    localparam logic [15:0] idx_ramp_rate  = 16'h3119;
    localparam logic [15:0] idx_tolerance  = 16'h311e;
    localparam logic [15:0] idx_sup_en     = 16'h311f;
    localparam logic [15:0] idx_roll_limit = 16'h3121;
    localparam logic [15:0] idx_settle     = 16'h321d;
    localparam logic [15:0] idx_tiedown    = 16'h32d6;
    localparam logic [15:0] idx_status     = 16'h3300;
    localparam logic [15:0] idx_mask       = 16'h3301;
    localparam logic [15:0] idx_state      = 16'h3302;
    // reset values in raw units
    localparam logic [15:0] rst_decel_hs   = 16'h05dc; // 1500 ms
    localparam logic [15:0] rst_decel_ls   = 16'h07d0; // 2000 ms
    localparam logic [15:0] rst_timeout    = 16'h0271; // 5.0 s in 8 ms units
    localparam logic [15:0] rst_ramp_delay = 16'h01f4; // 500 ms
    localparam logic [15:0] rst_ramp_rate  = 16'h1388; // 5000 ms
    localparam logic [15:0] rst_tolerance  = 16'h01f4; // 500 rpm
    localparam logic [15:0] rst_roll_limit = 16'ha000; // 10.0 rev, 4096 counts/rev
    localparam logic [15:0] rst_settle     = 16'h01f4; // 500 ms
    localparam logic [15:0] rst_tiedown    = 16'h0000;
    // time base: one millisecond tick
    localparam int          tick_ms        = 1;
    localparam int          tmo_unit_ms    = 8;     // one timeout raw count
    localparam int          clk_mhz        = 100;
    localparam int          ms_cycles      = tick_ms * clk_mhz * 1000;
    localparam logic [7:0]  persist_ms     = 8'h40; // 64 ms above envelope
    localparam logic [15:0] typ_max_rpm    = 16'h1770; // 6000 rpm reference
    // status bit positions
    localparam int st_tiedown = 0;
    localparam int st_overspd = 1;
    localparam int st_rollbk  = 2;
    localparam int st_timeout = 3;

    typedef enum logic [4:0] {
        s_idle   = 5'b00001,
        s_brake  = 5'b00010,
        s_settle = 5'b00100,
        s_coast  = 5'b01000,
        s_done   = 5'b10000
    } seq_t;

    typedef struct packed {
        logic [15:0] decel_hs, decel_ls, timeout, ramp_delay, ramp_rate;
        logic [15:0] tolerance, roll_limit, settle, tiedown;
        logic        enable, sup_en;
        logic [3:0]  mask;
    } cfg_t;

    typedef struct packed {
        logic        regen_stop;
        logic        bridge_en;
        logic        contactor;
        logic        parking_brake;
        logic [15:0] decel_rate;
    } drive_t;
endpackage

/* tb/ibs_chk.sv */
`timescale 1ns/100ps
module ibs_chk (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                interlock_in,
    input wire logic signed [15:0]  motor_rpm,
    input wire logic [15:0]         zero_speed_threshold,
    input wire logic [1:0]          parking_brake_kind,
    input wire ibs_pkg::drive_t     drive,
    input wire logic                tiedown_ok,
    input wire logic                irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one completed bus access
    sequence acc;
        psel && penable;
    endsequence
    // timeout escalation: brake applied while regen still runs
    sequence brake_on;
        $rose(drive.parking_brake) && drive.regen_stop;
    endsequence
    // the slave never stalls and never flags an error
    pready_high_a: assert property (acc |-> pready) else $error("access stalled");
    slverr_low_a: assert property (acc |-> !pslverr) else $error("error response");
    brake_kind_a: assert property (brake_on |-> !interlock_in &&
        parking_brake_kind inside {2'h1, 2'h2}) else $error("parking brake misapplied");
    // still moving with the brake on: regen must keep working against it
    regen_brake_a: assert property (drive.parking_brake &&
        motor_rpm > signed'({1'b0, zero_speed_threshold}) |-> drive.regen_stop)
        else $error("regen dropped under brake");
    regen_cause_a: assert property ($rose(drive.regen_stop) |->
        !$past(interlock_in, 2)) else $error("regen without interlock drop");
    regen_power_a: assert property (drive.regen_stop |->
        drive.bridge_en && drive.contactor) else $error("regen without power stage");
    // irq only falls from a status read or a mask write
    irq_clear_a: assert property ($fell(irq) |-> $past(psel && penable)
        || $past(psel && penable, 2)) else $error("irq fell unprompted");
    tiedown_a: assert property (!tiedown_ok |-> !$rose(drive.regen_stop))
        else $error("braking during tiedown window");
endmodule

bind interlock_brake_supervisor ibs_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .interlock_in(interlock_in),
    .motor_rpm(motor_rpm), .zero_speed_threshold(zero_speed_threshold),
    .parking_brake_kind(parking_brake_kind), .drive(drive), .tiedown_ok(tiedown_ok),
    .irq(irq));

/* tb/motor_model.sv */
`timescale 1ns/100ps
module motor_model (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire ibs_pkg::drive_t    drive,
    input wire logic               stuck,
    input wire logic               load,
    input wire logic signed [15:0] start_rpm,
    output logic signed [15:0]     motor_rpm,
    output logic signed [31:0]     motor_pos
);
    // regen pulls speed down; stuck models a load that regen cannot slow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            motor_rpm <= 16'sh0000;
            motor_pos <= 32'sh0000_0000;
        end
        else
        begin
            if (load)
                motor_rpm <= start_rpm;
            else if (drive.regen_stop && !stuck && motor_rpm > 16'sh0000)
                motor_rpm <= (motor_rpm > 16'sh0010) ? motor_rpm - 16'sh0010 : 16'sh0000;
            motor_pos <= motor_pos + 32'(motor_rpm >>> 6); // coarse travel
        end
    end
endmodule

/* tb/interlock_brake_supervisor_bench.sv */
`timescale 1ns/100ps
module interlock_brake_supervisor_bench;
    localparam int      ms_div_tb = 10;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               interlock_in, seq_delay_done, tiedown_ok, irq, stuck, load;
    logic [17:0]        paddr;
    logic [31:0]        pwdata, prdata, rd, v;
    logic signed [15:0] motor_rpm, start_rpm;
    logic signed [31:0] motor_pos;
    logic [1:0]         kind;
    ibs_pkg::drive_t    drive;
    int                 errors, checks_done, seed, n, i, k;
    logic [15:0]        regs [12];
    logic [15:0]        dflt [12];

    interlock_brake_supervisor #(.ms_div(ms_div_tb)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .interlock_in(interlock_in),
        .seq_delay_done(seq_delay_done), .motor_rpm(motor_rpm), .motor_pos(motor_pos),
        .zero_speed_threshold(16'h0032), .parking_brake_kind(kind),
        .high_speed_rpm(16'h05dc), .drive(drive), .tiedown_ok(tiedown_ok), .irq(irq));
    motor_model model (.pclk(pclk), .presetn(presetn), .drive(drive), .stuck(stuck),
        .load(load), .start_rpm(start_rpm), .motor_rpm(motor_rpm), .motor_pos(motor_pos));

    always #5 pclk = ~pclk;

    // timeout register counts 8 ms units
    function int tmo_cycles(input int raw);
        return raw * ibs_pkg::tmo_unit_ms * ms_div_tb;
    endfunction
    function logic brake_exp(input logic [1:0] kd);
        return kd == 2'h1 || kd == 2'h2;
    endfunction
    function logic pick(input int w);
        case (w)
            0: return drive.regen_stop;
            1: return drive.bridge_en;
            2: return drive.contactor;
            3: return drive.parking_brake;
            default: return irq;
        endcase
    endfunction
    // waits end 1 ns past the edge so outputs have settled
    task tick(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++w < 20);
        if (w >= 20)
            errors++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check("register", rd, exp);
    endtask
    task wait_bit(input int w, input logic val, input int lim);
        n = 0;
        while (pick(w) !== val && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask
    task rst;
        presetn <= 1'b0;
        interlock_in <= 1'b1;
        seq_delay_done <= 1'b0;
        stuck <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(1);
    endtask
    // load a random speed, then drop the interlock
    task spin(input logic s);
        start_rpm <= 16'sd2000 + 16'($random(seed) & 1023);
        load <= 1'b1;
        tick(1);
        load <= 1'b0;
        stuck <= s;
        interlock_in <= 1'b0;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #300000;
        errors++;
        end_sim;
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, load, kind} = '0;
        {paddr, pwdata, start_rpm} = '0;
        {errors, checks_done} = '0;
        seed = 97;
        regs = '{ibs_pkg::idx_decel_hs, ibs_pkg::idx_decel_ls, ibs_pkg::idx_enable,
            ibs_pkg::idx_timeout, ibs_pkg::idx_ramp_delay, ibs_pkg::idx_ramp_rate,
            ibs_pkg::idx_tolerance, ibs_pkg::idx_sup_en, ibs_pkg::idx_roll_limit,
            ibs_pkg::idx_settle, ibs_pkg::idx_tiedown, ibs_pkg::idx_mask};
        dflt = '{ibs_pkg::rst_decel_hs, ibs_pkg::rst_decel_ls, 16'h0001, ibs_pkg::rst_timeout,
            ibs_pkg::rst_ramp_delay, ibs_pkg::rst_ramp_rate, ibs_pkg::rst_tolerance, 16'h0001,
            ibs_pkg::rst_roll_limit, ibs_pkg::rst_settle, ibs_pkg::rst_tiedown, 16'h0000};
        rst;
        check("tiedown_ok", tiedown_ok, 1'b1);
        for (i = 0; i < 12; i++)
            rd_chk(regs[i], {16'h0, dflt[i]});
        apb(1'b1, 16'h0100, 32'h1234);
        rd_chk(16'h0100, 32'h0);
        // random in-range values for the numeric registers
        for (i = 0; i < 11; i++)
        begin
            if (i == 2 || i == 7)
                continue;
            v = 32'd410 + 32'($random(seed) & 511);
            apb(1'b1, regs[i], v);
            rd_chk(regs[i], v);
        end
        // timeout escalation for every brake kind, speed held up
        for (k = 0; k < 4; k++)
        begin
            rst;
            kind <= 2'(k);
            apb(1'b1, ibs_pkg::idx_timeout, 32'h2);
            apb(1'b1, ibs_pkg::idx_mask, 32'h8);
            spin(1'b1);
            wait_bit(0, 1'b1, 20);
            check("regen_stop", drive.regen_stop, 1'b1);
            tick(tmo_cycles(2) - 40);
            check("early brake", drive.parking_brake, 1'b0);
            wait_bit(3, 1'b1, 80);
            check("parking_brake", drive.parking_brake, brake_exp(kind));
            check("regen kept", drive.regen_stop, 1'b1);
            check("irq", irq, brake_exp(kind));
            apb(1'b0, ibs_pkg::idx_status, 32'h0);
            check("timeout status", rd & 32'h8, brake_exp(kind) ? 32'h8 : 32'h0);
            tick(2);
            check("irq cleared", irq, 1'b0);
        end
        // braking disabled: coast once the sequencer is done
        rst;
        apb(1'b1, ibs_pkg::idx_enable, 32'h0);
        spin(1'b1);
        tick(20);
        check("bridge held", drive.bridge_en, 1'b1);
        check("no regen", drive.regen_stop, 1'b0);
        seq_delay_done <= 1'b1;
        wait_bit(1, 1'b0, 20);
        check("bridge off", drive.bridge_en, 1'b0);
        // settling hold after zero speed, 50 cycles
        rst;
        kind <= 2'h0;
        apb(1'b1, ibs_pkg::idx_settle, 32'h5);
        spin(1'b0);
        for (n = 0; motor_rpm > 16'sd50 && n < 600; n++)
            tick(1);
        tick(40);
        check("contactor held", drive.contactor & drive.bridge_en, 1'b1);
        wait_bit(2, 1'b0, 100);
        check("contactor open", drive.contactor, 1'b0);
        // supervision on then off, speed refusing to fall
        for (k = 0; k < 2; k++)
        begin
            rst;
            apb(1'b1, ibs_pkg::idx_ramp_delay, 32'h0);
            apb(1'b1, ibs_pkg::idx_ramp_rate, 32'd100);
            apb(1'b1, ibs_pkg::idx_tolerance, 32'h0);
            apb(1'b1, ibs_pkg::idx_sup_en, 32'(k == 0));
            apb(1'b1, ibs_pkg::idx_mask, 32'h2);
            spin(1'b1);
            if (k == 0)
                wait_bit(4, 1'b1, 2500);
            else
                tick(1000);
            check("overspeed irq", irq, k == 0);
        end
        end_sim;
    end
endmodule
